// *** common/prot_seq_cfg.svh ***
// Timing, level and count constants of the flyback protection sequencer
// How it works
// - Protection pin alternates mains/temperature, 500 us each
// - Pin below 2.0 V four temperature phases latches
// - Temperature source is 200 uA minus stored mains
// - Line correction is half the excess over 6.24 uA
// - Line correction off below 350 mV control
// - Secondary sample above 2.5 V four cycles latches
// - Skip first 2 us of secondary stroke
// - Sense pin: peak in primary, overvoltage in secondary
// - Overpower timer starts above 400 mV control
// - Overpower timer clears when control drops back
// - Timeout stops switching; restart or latch by variant
// - Timeout 27.5/14.5 ms restart, 160 ms latch
// - Slow restart cycles supply three times first
// - Timeout counts ticks of 3.8 ms jitter clock
// - Latched-off holds until supply reset
`ifndef PROT_SEQ_CFG_SVH
`define PROT_SEQ_CFG_SVH

// ----------------------------------------------------------------
// Clock and phase timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define PHASE_TIME_US 500
`define PHASE_CYCLES ((`PHASE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BLANK_TIME_NS 2000
`define BLANK_CYCLES 9'((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Currents in units of 0.01 uA, control level in mV
// ----------------------------------------------------------------
`define TEMP_SRC_CU 15'h4e20
`define OPC_KNEE_CU 13'h0270
`define CTRL_OPC_MV 10'h15e
`define CTRL_OPP_MV 10'h190

// ----------------------------------------------------------------
// Overpower timeout in jitter clock periods, rounded up
// ----------------------------------------------------------------
`define JIT_PERIOD_US 3800
`define OPP_LONG_US 27500
`define OPP_SHORT_US 14500
`define OPP_LATCH_US 160000
`define JIT_TICKS(t) 6'(((t) + `JIT_PERIOD_US - 1) / `JIT_PERIOD_US)

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define CONSEC_FAULTS 3'h4
`define SYNC_SETTLE 2'h3
`define SR_LAST_CYCLE 2'h2

`endif

// *** common/prot_seq_pkg.sv ***
// Types shared by the protection sequencer files
package prot_seq_pkg;

   // Top-level operating state
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SR_DISCH = 2'b01,
      ST_SR_CHARGE = 2'b10,
      ST_LATCH = 2'b11
   } seq_state_e;

endpackage

// *** hdl/consec_fault_cnt.sv ***
// Counter that trips after four consecutive faulty evaluations
`timescale 1ns/10ps
`include "prot_seq_cfg.svh"

module consec_fault_cnt (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic eval,
   input wire logic fault,
   output logic trip
);

   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;

   // Count faulty evaluations, clear on a passing one
   assign cnt_nxt = !eval ? cnt_r :
                    !fault ? 3'h0 :
                    (cnt_r == `CONSEC_FAULTS) ? cnt_r : cnt_r + 3'h1;
   assign trip = (cnt_r == `CONSEC_FAULTS);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   AST_CLEAR_ON_PASS: assert property (@(posedge clk) disable iff (!reset_n)
      eval && !fault |=> cnt_r == 3'h0)
      else $error("fault count not cleared by passing evaluation");

endmodule

// *** hdl/flyback_prot_seq.sv ***
// Protection sequencer: pin multiplexing, OTP, OVP, OPP and slow restart
`timescale 1ns/10ps
`include "prot_seq_cfg.svh"

module flyback_prot_seq #(
   parameter int PHASE_CYC = `PHASE_CYCLES
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PROT_ABOVE_2V,
   input wire logic CS_ABOVE_2V5,
   input wire logic JITTER_CLK,
   input wire logic VOUT_LOW,
   input wire logic VCC_AT_STARTUP,
   input wire logic VCC_BELOW_UVLO,
   input wire logic LATCH_VARIANT,
   input wire logic PRIM_STROKE,
   input wire logic SEC_STROKE,
   input wire logic [12:0] MAINS_CUR,
   input wire logic [9:0] CTRL_LEVEL,
   output logic TEMP_PHASE,
   output logic [14:0] TEMP_SRC_CUR,
   output logic [11:0] OPC_CUR,
   output logic CS_PEAK_SEL,
   output logic CS_OVP_SEL,
   output logic SWITCH_EN,
   output logic POWER_DOWN,
   output logic VCC_DISCHARGE,
   output logic SLOW_RESTART,
   output logic LATCHED
);

   localparam logic [15:0] PHASE_LAST = 16'(PHASE_CYC - 1);

   // ----------------------------------------------------------------
   // Synchronisers for pin and foreign-clock inputs
   // ----------------------------------------------------------------
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic prot_above;
   logic cs_above;
   logic jit_s;
   logic vout_low;
   logic vcc_startup;
   logic vcc_uvlo;
   logic latch_var;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
      end else begin
         sync1_r <= {LATCH_VARIANT, VCC_BELOW_UVLO, VCC_AT_STARTUP, VOUT_LOW,
                     JITTER_CLK, CS_ABOVE_2V5, PROT_ABOVE_2V};
         sync2_r <= sync1_r;
      end
   end

   assign {latch_var, vcc_uvlo, vcc_startup, vout_low, jit_s, cs_above, prot_above} = sync2_r;

   // ----------------------------------------------------------------
   // Protection pin phases, stored mains current, line correction
   // ----------------------------------------------------------------
   logic [15:0] phase_cnt_r;
   logic temp_phase_r;
   logic [12:0] mains_store_r;
   logic all_low_r;
   logic phase_end;
   logic otp_eval;
   logic otp_fault;
   logic all_low_nxt;
   logic opc_on;
   logic [12:0] opc_excess;
   logic [14:0] temp_src_nxt;
   logic [11:0] opc_nxt;

   assign phase_end = (phase_cnt_r == PHASE_LAST);
   assign otp_eval = phase_end && temp_phase_r;
   assign otp_fault = all_low_r && !prot_above;
   assign all_low_nxt = !temp_phase_r ? 1'b1 : (all_low_r && !prot_above);
   assign temp_src_nxt = `TEMP_SRC_CU - 15'(mains_store_r);
   assign opc_on = (CTRL_LEVEL >= `CTRL_OPC_MV) && (mains_store_r > `OPC_KNEE_CU);
   assign opc_excess = mains_store_r - `OPC_KNEE_CU;
   assign opc_nxt = opc_on ? opc_excess[12:1] : 12'h000;

   // Phase timer and mains reference capture
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phase_cnt_r <= 16'h0000;
         temp_phase_r <= 1'b0;
         mains_store_r <= 13'h0000;
         all_low_r <= 1'b1;
      end else begin
         phase_cnt_r <= phase_end ? 16'h0000 : phase_cnt_r + 16'h0001;
         temp_phase_r <= phase_end ? !temp_phase_r : temp_phase_r;
         mains_store_r <= (phase_end && !temp_phase_r) ? MAINS_CUR : mains_store_r;
         all_low_r <= phase_end ? 1'b1 : all_low_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Secondary-stroke overvoltage sampling on the sense pin
   // ----------------------------------------------------------------
   logic [8:0] blank_cnt_r;
   logic ovp_eval;
   logic blank_done;

   assign blank_done = (blank_cnt_r == `BLANK_CYCLES);
   assign ovp_eval = SEC_STROKE && (blank_cnt_r == `BLANK_CYCLES - 9'h001);

   // Blanking counter restarts with every secondary stroke
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         blank_cnt_r <= 9'h000;
      end else begin
         blank_cnt_r <= !SEC_STROKE ? 9'h000 : blank_done ? blank_cnt_r : blank_cnt_r + 9'h001;
      end
   end

   logic otp_trip;
   logic ovp_trip;

   consec_fault_cnt u_otp_cnt (
      .clk(CLK),
      .reset_n(RESET_N),
      .eval(otp_eval),
      .fault(otp_fault),
      .trip(otp_trip)
   );

   consec_fault_cnt u_ovp_cnt (
      .clk(CLK),
      .reset_n(RESET_N),
      .eval(ovp_eval),
      .fault(cs_above),
      .trip(ovp_trip)
   );

   // ----------------------------------------------------------------
   // Overpower timer on the jitter clock
   // ----------------------------------------------------------------
   prot_seq_pkg::seq_state_e state_r;
   prot_seq_pkg::seq_state_e state_nxt;
   logic jit_d_r;
   logic [5:0] opp_ticks_r;
   logic jit_tick;
   logic opp_over;
   logic [5:0] opp_limit;
   logic opp_timeout;
   logic [1:0] sr_cnt_r;
   logic [1:0] settle_r;

   // No tick until the sync chain and edge flop hold real samples
   assign jit_tick = jit_s && !jit_d_r && (settle_r == `SYNC_SETTLE);
   assign opp_over = (CTRL_LEVEL > `CTRL_OPP_MV) && (state_r == prot_seq_pkg::ST_RUN);
   assign opp_limit = latch_var ? `JIT_TICKS(`OPP_LATCH_US) :
                      vout_low ? `JIT_TICKS(`OPP_SHORT_US) : `JIT_TICKS(`OPP_LONG_US);
   assign opp_timeout = opp_over && jit_tick && (opp_ticks_r == opp_limit - 6'h01);

   // Timer counts jitter periods, cleared at once when level drops
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         jit_d_r <= 1'b0;
         settle_r <= 2'h0;
         opp_ticks_r <= 6'h00;
      end else begin
         jit_d_r <= jit_s;
         settle_r <= (settle_r == `SYNC_SETTLE) ? settle_r : settle_r + 2'h1;
         opp_ticks_r <= (!opp_over || opp_timeout) ? 6'h00 :
                        jit_tick ? opp_ticks_r + 6'h01 : opp_ticks_r;
      end
   end

   // ----------------------------------------------------------------
   // Run, slow restart and latched-off sequencing
   // ----------------------------------------------------------------
   logic any_latch;
   logic sr_done;

   assign any_latch = otp_trip || ovp_trip || (opp_timeout && latch_var);
   assign sr_done = vcc_startup && (sr_cnt_r == `SR_LAST_CYCLE);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         prot_seq_pkg::ST_RUN: begin
            if (opp_timeout) begin
               state_nxt = prot_seq_pkg::ST_SR_DISCH;
            end
         end
         prot_seq_pkg::ST_SR_DISCH: begin
            if (vcc_uvlo) begin
               state_nxt = prot_seq_pkg::ST_SR_CHARGE;
            end
         end
         prot_seq_pkg::ST_SR_CHARGE: begin
            if (sr_done) begin
               state_nxt = prot_seq_pkg::ST_RUN;
            end else if (vcc_startup) begin
               state_nxt = prot_seq_pkg::ST_SR_DISCH;
            end
         end
         prot_seq_pkg::ST_LATCH: begin
            state_nxt = prot_seq_pkg::ST_LATCH;
         end
      endcase
      if (any_latch) begin
         state_nxt = prot_seq_pkg::ST_LATCH;
      end
   end

   // State, restart cycle count and registered outputs
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= prot_seq_pkg::ST_RUN;
         sr_cnt_r <= 2'h0;
         TEMP_PHASE <= 1'b0;
         TEMP_SRC_CUR <= `TEMP_SRC_CU;
         OPC_CUR <= 12'h000;
         CS_PEAK_SEL <= 1'b0;
         CS_OVP_SEL <= 1'b0;
         SWITCH_EN <= 1'b1;
         POWER_DOWN <= 1'b0;
         VCC_DISCHARGE <= 1'b0;
         SLOW_RESTART <= 1'b0;
         LATCHED <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sr_cnt_r <= (state_r == prot_seq_pkg::ST_RUN) ? 2'h0 :
                     (state_r == prot_seq_pkg::ST_SR_CHARGE && vcc_startup) ?
                     sr_cnt_r + 2'h1 : sr_cnt_r;
         TEMP_PHASE <= temp_phase_r;
         TEMP_SRC_CUR <= temp_src_nxt;
         OPC_CUR <= opc_nxt;
         CS_PEAK_SEL <= PRIM_STROKE;
         CS_OVP_SEL <= SEC_STROKE && !PRIM_STROKE && blank_cnt_r >= `BLANK_CYCLES - 9'h001;
         SWITCH_EN <= (state_nxt == prot_seq_pkg::ST_RUN);
         POWER_DOWN <= (state_nxt != prot_seq_pkg::ST_RUN);
         VCC_DISCHARGE <= (state_nxt == prot_seq_pkg::ST_SR_DISCH);
         SLOW_RESTART <= (state_nxt == prot_seq_pkg::ST_SR_DISCH) ||
                         (state_nxt == prot_seq_pkg::ST_SR_CHARGE);
         LATCHED <= (state_nxt == prot_seq_pkg::ST_LATCH);
      end
   end

   // ----------------------------------------------------------------
   // Assertions and covers
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   AST_PHASE_LENGTH: assert property ($changed(temp_phase_r) |-> $past(phase_cnt_r) == PHASE_LAST)
      else $error("phase changed before its full length");
   AST_OTP_LATCH: assert property (otp_trip |=> LATCHED && !SWITCH_EN)
      else $error("temperature fault did not latch");
   AST_TEMP_SOURCE: assert property (##1 TEMP_SRC_CUR == `TEMP_SRC_CU - 15'($past(mains_store_r)))
      else $error("temperature source not reduced by mains current");
   AST_OPC_KNEE: assert property (mains_store_r <= `OPC_KNEE_CU |=> OPC_CUR == 12'h000)
      else $error("line correction below knee");
   AST_OPC_LOW_CTRL: assert property (CTRL_LEVEL < `CTRL_OPC_MV |=> OPC_CUR == 12'h000)
      else $error("line correction active at low control level");
   AST_OVP_LATCH: assert property (ovp_trip |=> LATCHED ##1 LATCHED)
      else $error("overvoltage fault did not latch");
   AST_BLANKING: assert property ($rose(SEC_STROKE) |=> !CS_OVP_SEL [*8])
      else $error("overvoltage sample inside blanking");
   AST_PRIMARY_PEAK: assert property (PRIM_STROKE |=> CS_PEAK_SEL && !CS_OVP_SEL)
      else $error("sense pin not on peak path in primary stroke");
   AST_OPP_COUNT: assert property (opp_over && jit_tick && !opp_timeout |=>
      opp_ticks_r == $past(opp_ticks_r) + 6'h01)
      else $error("overpower timer did not advance");
   AST_OPP_CLEAR: assert property (!opp_over |=> opp_ticks_r == 6'h00)
      else $error("overpower timer not cleared");
   AST_OPP_STOP: assert property (opp_timeout |=> !SWITCH_EN && (LATCHED || SLOW_RESTART))
      else $error("overpower timeout did not stop switching");
   AST_OPP_LIMIT: assert property (opp_timeout && !latch_var && !vout_low |-> opp_ticks_r == 6'h07)
      else $error("restart timeout length wrong");
   AST_SR_RESUME: assert property (state_r == prot_seq_pkg::ST_SR_CHARGE && sr_done && !any_latch
      |=> SWITCH_EN)
      else $error("switching not resumed after third supply cycle");
   AST_LATCH_HOLD: assert property (LATCHED |=> LATCHED && POWER_DOWN && !SWITCH_EN)
      else $error("latched-off state released");

   COV_OTP_TRIP: cover property (otp_trip);
   COV_OVP_TRIP: cover property (ovp_trip);
   COV_SLOW_RESTART_DONE: cover property ($rose(SLOW_RESTART) ##[1:1000] $fell(SLOW_RESTART));
   COV_OPP_CLEARED: cover property (opp_ticks_r != 6'h00 ##1 opp_ticks_r == 6'h00 && !opp_over);

endmodule

// *** sim/flyback_protection_sequencer_tb.sv ***
// Self-checking bench for the flyback protection sequencer
`timescale 1ns/10ps
module flyback_protection_sequencer_tb;
   localparam int PH = 20;
   localparam int JP = 40;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic CS_ABOVE_2V5 = 1'b0;
   logic JITTER_CLK = 1'b0;
   logic VOUT_LOW = 1'b0;
   logic LATCH_VARIANT = 1'b0;
   logic PRIM_STROKE = 1'b0;
   logic SEC_STROKE = 1'b0;
   logic [12:0] MAINS_CUR = 13'h0a00;
   logic [9:0] CTRL_LEVEL = 10'h000;
   logic ntc_hot = 1'b0;
   logic PROT_ABOVE_2V, VCC_AT_STARTUP, VCC_BELOW_UVLO, TEMP_PHASE, CS_PEAK_SEL, CS_OVP_SEL;
   logic SWITCH_EN, POWER_DOWN, VCC_DISCHARGE, SLOW_RESTART, LATCHED;
   logic [14:0] TEMP_SRC_CUR;
   logic [11:0] OPC_CUR;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int jit = 0;
   int drops = 0;

   flyback_prot_seq #(.PHASE_CYC(PH)) dut (
      .CLK(CLK), .RESET_N(RESET_N), .PROT_ABOVE_2V(PROT_ABOVE_2V),
      .CS_ABOVE_2V5(CS_ABOVE_2V5), .JITTER_CLK(JITTER_CLK), .VOUT_LOW(VOUT_LOW),
      .VCC_AT_STARTUP(VCC_AT_STARTUP), .VCC_BELOW_UVLO(VCC_BELOW_UVLO),
      .LATCH_VARIANT(LATCH_VARIANT), .PRIM_STROKE(PRIM_STROKE), .SEC_STROKE(SEC_STROKE),
      .MAINS_CUR(MAINS_CUR), .CTRL_LEVEL(CTRL_LEVEL), .TEMP_PHASE(TEMP_PHASE),
      .TEMP_SRC_CUR(TEMP_SRC_CUR), .OPC_CUR(OPC_CUR), .CS_PEAK_SEL(CS_PEAK_SEL),
      .CS_OVP_SEL(CS_OVP_SEL), .SWITCH_EN(SWITCH_EN), .POWER_DOWN(POWER_DOWN),
      .VCC_DISCHARGE(VCC_DISCHARGE), .SLOW_RESTART(SLOW_RESTART), .LATCHED(LATCHED));

   sense_supply_model #(.RAMP(30)) env (
      .clk(CLK), .temp_phase(TEMP_PHASE), .vcc_discharge(VCC_DISCHARGE), .ntc_hot(ntc_hot),
      .prot_above_2v(PROT_ABOVE_2V), .vcc_at_startup(VCC_AT_STARTUP),
      .vcc_below_uvlo(VCC_BELOW_UVLO));

   always #4 CLK = ~CLK;
   // Shortened jitter clock and run watchdog
   always @(posedge CLK) begin
      jit <= (jit == JP - 1) ? 0 : jit + 1;
      JITTER_CLK <= (jit < JP / 2);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic do_reset(input logic lv);
      @(posedge CLK);
      RESET_N <= 1'b0;
      LATCH_VARIANT <= lv;
      CTRL_LEVEL <= 10'h000;
      ntc_hot <= 1'b0;
      repeat (4) @(posedge CLK);
      RESET_N <= 1'b1;
      #1;
      check("latched_rst", LATCHED, 1'b0);
      check("switch_rst", SWITCH_EN, 1'b1);
      check("src_rst", TEMP_SRC_CUR, 15'h4e20);
   endtask
   task automatic stroke(input int len, input logic hi);
      @(posedge CLK);
      PRIM_STROKE <= 1'b1;
      repeat (4) @(posedge CLK);
      #1;
      check("peak_sel", CS_PEAK_SEL, 1'b1);
      check("ovp_sel_prim", CS_OVP_SEL, 1'b0);
      @(posedge CLK);
      PRIM_STROKE <= 1'b0;
      SEC_STROKE <= 1'b1;
      CS_ABOVE_2V5 <= hi;
      repeat (200) @(posedge CLK);
      #1;
      check("ovp_sel_blank", CS_OVP_SEL, 1'b0);
      repeat (len - 201) @(posedge CLK);
      #1;
      if (len > 260) check("ovp_sel", CS_OVP_SEL, 1'b1);
      @(posedge CLK);
      SEC_STROKE <= 1'b0;
      CS_ABOVE_2V5 <= 1'b0;
      repeat (20) @(posedge CLK);
      #1;
   endtask
   task automatic hold(input int n);
      repeat (n) begin
         @(posedge CLK);
         #1;
         if (SWITCH_EN !== 1'b1) drops++;
      end
   endtask
   task automatic otp_phases(input int n, input logic hot);
      @(posedge CLK);
      ntc_hot <= hot;
      repeat (n) @(negedge TEMP_PHASE);
      repeat (4) @(posedge CLK);
      #1;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_phase();
      int n = 0;
      @(posedge CLK);
      CTRL_LEVEL <= 10'h15e;
      @(posedge TEMP_PHASE);
      #1;
      check("src_mains", TEMP_SRC_CUR, 15'h4420);
      check("opc", OPC_CUR, 12'h3c8);
      while (TEMP_PHASE === 1'b1 && n < 100) begin
         @(posedge CLK);
         #1;
         n++;
      end
      check("phase_len", 16'(n), 16'(PH));
      @(posedge CLK);
      CTRL_LEVEL <= 10'h15d;
      MAINS_CUR <= 13'h0272;
      repeat (2) @(posedge CLK);
      #1;
      check("opc_low_ctrl", OPC_CUR, 12'h000);
      @(posedge CLK);
      CTRL_LEVEL <= 10'h15e;
      repeat (2) @(posedge TEMP_PHASE);
      #1;
      check("src_knee", TEMP_SRC_CUR, 15'h4bae);
      check("opc_knee", OPC_CUR, 12'h001);
   endtask
   task automatic test_ovp();
      logic [6:0] pat = 7'b1110111;
      do_reset(1'b0);
      for (int i = 0; i < 7; i++) stroke(300, pat[i]);
      stroke(249, 1'b1);
      check("ovp_no_trip", LATCHED, 1'b0);
      stroke(300, 1'b1);
      check("ovp_trip", LATCHED, 1'b1);
      check("ovp_off", SWITCH_EN, 1'b0);
      check("ovp_pd", POWER_DOWN, 1'b1);
   endtask
   task automatic test_otp();
      do_reset(1'b0);
      otp_phases(3, 1'b1);
      otp_phases(1, 1'b0);
      otp_phases(3, 1'b1);
      check("otp_no_trip", LATCHED, 1'b0);
      otp_phases(1, 1'b1);
      check("otp_trip", LATCHED, 1'b1);
   endtask
   task automatic test_opp_hold();
      logic [9:0] lvl [3] = '{10'h191, 10'h190, 10'h191};
      int dur [3] = '{5, 10, 5};
      do_reset(1'b0);
      drops = 0;
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK);
         CTRL_LEVEL <= lvl[i];
         hold(dur[i] * JP);
      end
      check("opp_drops", 16'(drops), 16'h0000);
   endtask
   task automatic opp_trip(input logic lv, input logic vl, input int ticks);
      int n = 0;
      int k = 0;
      logic prev;
      do_reset(lv);
      @(posedge CLK);
      VOUT_LOW <= vl;
      CTRL_LEVEL <= 10'h191;
      while (SWITCH_EN === 1'b1 && n < 2000) begin
         @(posedge CLK);
         #1;
         n++;
      end
      check("opp_min", n >= (ticks - 1) * JP, 1'b1);
      check("opp_max", n <= ticks * JP + 8, 1'b1);
      repeat (2) @(posedge CLK);
      CTRL_LEVEL <= 10'h000;
      #1;
      check("opp_latched", LATCHED, lv);
      check("opp_restart", SLOW_RESTART, !lv);
      check("opp_disch", VCC_DISCHARGE, !lv);
      prev = VCC_AT_STARTUP;
      n = 0;
      while (SWITCH_EN !== 1'b1 && n < 2000) begin
         @(posedge CLK);
         #1;
         if (VCC_AT_STARTUP && !prev) k++;
         prev = VCC_AT_STARTUP;
         n++;
      end
      check("startups", 16'(k), lv ? 16'h0000 : 16'h0003);
      check("resumed", SWITCH_EN, !lv);
   endtask

   initial begin
      do_reset(1'b0);
      check("pd_rst", POWER_DOWN, 1'b0);
      test_phase();
      test_ovp();
      test_otp();
      test_opp_hold();
      opp_trip(1'b0, 1'b0, 8);
      opp_trip(1'b0, 1'b1, 4);
      opp_trip(1'b1, 1'b1, 43);
      give_verdict();
   end
endmodule

// *** sim/sense_supply_model.sv ***
// Analog side model: NTC network on the protection pin and supply capacitor
`timescale 1ns/10ps
module sense_supply_model #(
   parameter int RAMP = 30
) (
   input wire logic clk,
   input wire logic temp_phase,
   input wire logic vcc_discharge,
   input wire logic ntc_hot,
   output logic prot_above_2v,
   output logic vcc_at_startup,
   output logic vcc_below_uvlo
);
   int vcc = RAMP;
   // Pin clamped low in mains phase; a hot NTC keeps it under 2.0 V
   always @(posedge clk) begin
      prot_above_2v <= temp_phase && !ntc_hot;
   end
   // Discharge source pulls the supply down, start-up circuit charges it
   always @(posedge clk) begin
      if (vcc_discharge && vcc > 0) begin
         vcc <= vcc - 1;
      end else if (!vcc_discharge && vcc < RAMP) begin
         vcc <= vcc + 1;
      end
   end
   assign vcc_at_startup = (vcc == RAMP);
   assign vcc_below_uvlo = (vcc == 0);
endmodule
